// file: rtl/sars_regs.svh
// Constants for the successive-approximation converter sequencer.
// Assumes inclusion by the sequencer package user; definitions only.
`ifndef SARS_REGS_SVH
`define SARS_REGS_SVH

`define SARS_RES_W        10
`define SARS_DIV_W        5
`define SARS_MUX_W        5
`define SARS_MUX_GND      5'h1F
`define SARS_MUX_COUNT    23
`define SARS_TRACK_CLKS   2'h3
`define SARS_SRC_SW       3'h0
`define SARS_SRC_T0       3'h1
`define SARS_SRC_T2       3'h2
`define SARS_SRC_T1       3'h3
`define SARS_SRC_EXT      3'h4
`define SARS_SRC_T3       3'h5
`define SARS_LJ_PAD       6
`define SARS_RJ_PAD       6
`define SARS_BIT_MSB      4'h9

`endif

// file: rtl/sars_pkg.sv
// Types for the successive-approximation converter sequencer.
// Assumes sars_regs.svh supplies the widths.
`include "sars_regs.svh"

package sars_pkg;

  typedef enum logic [3:0] {
    SARS_IDLE  = 4'b0001,
    SARS_TRACK = 4'b0010,
    SARS_CONV  = 4'b0100,
    SARS_DONE  = 4'b1000
  } sars_state_e;

  typedef struct packed {
    sars_state_e               state;
    logic [`SARS_DIV_W-1:0]    div_cnt;
    logic [1:0]                trk_cnt;
    logic [3:0]                bit_idx;
    logic [`SARS_RES_W-1:0]    sar;
    logic [15:0]               result;
    logic                      busy;
    logic                      done;
    logic                      ext_prev;
    logic                      ext_armed;
  } sars_state_s;

endpackage

// file: rtl/sars_seq.sv
// Digital sequencer for a 10-bit successive-approximation converter.
// Assumes synchronous control inputs and an analog comparator answering
// within one conversion-clock period of each trial code.
`include "sars_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sars_seq (
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   converter_enable_bit_i,
  input  wire logic [`SARS_MUX_W-1:0] positive_input_select_i,
  input  wire logic [`SARS_MUX_W-1:0] negative_input_select_i,
  input  wire logic                   left_justify_select_i,
  input  wire logic [`SARS_DIV_W-1:0] conversion_clock_divider_i,
  input  wire logic [2:0]             start_source_select_i,
  input  wire logic                   low_power_track_select_i,
  input  wire logic                   busy_write_one_i,
  input  wire logic                   timer0_ovf_i,
  input  wire logic                   timer1_ovf_i,
  input  wire logic                   timer2_low_ovf_i,
  input  wire logic                   timer2_high_ovf_i,
  input  wire logic                   timer2_split_i,
  input  wire logic                   timer3_low_ovf_i,
  input  wire logic                   timer3_high_ovf_i,
  input  wire logic                   timer3_split_i,
  input  wire logic                   external_convert_start_i,
  input  wire logic                   done_clear_i,
  input  wire logic                   interrupt_enable_i,
  input  wire logic                   comparator_high_i,
  output logic                        conversion_in_progress_bit_o,
  output logic                        conversion_done_flag_o,
  output logic                        interrupt_req_o,
  output logic                        track_o,
  output logic                        differential_o,
  output logic [`SARS_MUX_W-1:0]      mux_pos_o,
  output logic [`SARS_MUX_W-1:0]      mux_neg_o,
  output logic [`SARS_RES_W-1:0]      sar_trial_o,
  output logic [7:0]                  result_high_byte_o,
  output logic [7:0]                  result_low_byte_o
);

  // ****************************************************************
  // Formatting
  // ****************************************************************
  function automatic logic [15:0] sars_format(input logic [`SARS_RES_W-1:0] code,
                                              input logic diff, input logic ljust);
    logic [15:0] r;
    r = 16'h0000;
    if (ljust) begin
      r = {code, {`SARS_LJ_PAD{1'b0}}};
    end else if (diff) begin
      r = {{`SARS_RJ_PAD{code[`SARS_RES_W-1]}}, code};
    end else begin
      r = {{`SARS_RJ_PAD{1'b0}}, code};
    end
    return r;
  endfunction

  sars_pkg::sars_state_s q, d;
  logic start_evt;
  logic ext_rise;
  logic sar_tick;
  logic diff;

  // The analog mux decodes all 23 selections; this block routes codes and only tests the negative one against ground.
  assign mux_pos_o      = positive_input_select_i;
  assign mux_neg_o      = negative_input_select_i;
  assign diff           = (negative_input_select_i != `SARS_MUX_GND);
  assign differential_o = diff;
  assign ext_rise       = external_convert_start_i & ~q.ext_prev;
  assign sar_tick       = (q.div_cnt == conversion_clock_divider_i);

  // ****************************************************************
  // Start source selection
  // ****************************************************************
  always_comb begin
    unique case (start_source_select_i)
      `SARS_SRC_SW:  start_evt = busy_write_one_i;
      `SARS_SRC_T0:  start_evt = timer0_ovf_i;
      `SARS_SRC_T2:  start_evt = timer2_split_i ? timer2_low_ovf_i : timer2_high_ovf_i;
      `SARS_SRC_T1:  start_evt = timer1_ovf_i;
      `SARS_SRC_EXT: start_evt = ext_rise;
      `SARS_SRC_T3:  start_evt = timer3_split_i ? timer3_low_ovf_i : timer3_high_ovf_i;
      default:       start_evt = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    d          = q;
    d.ext_prev = external_convert_start_i;
    d.div_cnt  = sar_tick ? '0 : q.div_cnt + 1'b1;
    if (done_clear_i) begin
      d.done = 1'b0;
    end
    // External start in low-power mode: tracking while low, convert at rise.
    d.ext_armed = ~external_convert_start_i;
    unique case (q.state)
      sars_pkg::SARS_IDLE: begin
        // Busy still stands in the cycle after DONE; a start there must be refused
        if (converter_enable_bit_i && start_evt && !q.busy) begin
          d.busy    = 1'b1;
          d.div_cnt = '0;
          d.sar     = '0;
          d.bit_idx = `SARS_BIT_MSB;
          d.trk_cnt = '0;
          if (low_power_track_select_i && start_source_select_i != `SARS_SRC_EXT) begin
            d.state = sars_pkg::SARS_TRACK;
          end else begin
            d.state = sars_pkg::SARS_CONV;
          end
        end
      end
      sars_pkg::SARS_TRACK: begin
        if (sar_tick) begin
          d.trk_cnt = q.trk_cnt + 1'b1;
          if (q.trk_cnt == `SARS_TRACK_CLKS - 2'h1) begin
            d.state = sars_pkg::SARS_CONV;
          end
        end
      end
      sars_pkg::SARS_CONV: begin
        if (sar_tick) begin
          d.sar[q.bit_idx] = comparator_high_i;
          d.bit_idx        = q.bit_idx - 4'h1;
          if (q.bit_idx == 4'h0) begin
            d.state = sars_pkg::SARS_DONE;
          end
        end
      end
      sars_pkg::SARS_DONE: begin
        // Result lands a cycle ahead of busy falling, so done never sees stale data.
        d.result = sars_format(q.sar, diff, left_justify_select_i);
        d.state  = sars_pkg::SARS_IDLE;
      end
    endcase
    if (q.state == sars_pkg::SARS_IDLE && q.busy) begin
      d.busy = 1'b0;
      d.done = 1'b1;
    end
    // Abort from any state, so a disabled unit never reports completion
    if (!converter_enable_bit_i) begin
      d.state = sars_pkg::SARS_IDLE;
      d.busy  = 1'b0;
      d.done  = q.done & ~done_clear_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{state: sars_pkg::SARS_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    sar_trial_o = q.sar;
    if (q.state == sars_pkg::SARS_CONV) begin
      sar_trial_o[q.bit_idx] = 1'b1;
    end
  end

  assign conversion_in_progress_bit_o = q.busy;
  assign conversion_done_flag_o       = q.done;
  assign interrupt_req_o              = q.done & interrupt_enable_i;
  assign track_o = converter_enable_bit_i &&
                   (low_power_track_select_i ?
                    (q.state == sars_pkg::SARS_TRACK ||
                     (start_source_select_i == `SARS_SRC_EXT && q.state == sars_pkg::SARS_IDLE && q.ext_armed)) :
                    !q.busy);
  assign result_high_byte_o = q.result[15:8];
  assign result_low_byte_o  = q.result[7:0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_busy_fall;
    $fell(q.busy) && $past(converter_enable_bit_i);
  endsequence

  chk_done_on_fall: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_busy_fall |-> q.done) else $error("done flag not set at busy fall");
  chk_no_start_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !converter_enable_bit_i |=> !q.busy) else $error("busy while disabled");
  chk_busy_held: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (q.state == sars_pkg::SARS_CONV) |-> q.busy) else $error("busy low during conversion");
  chk_result_first: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (q.state == sars_pkg::SARS_DONE) && converter_enable_bit_i |=> q.busy ##1 !q.busy)
    else $error("busy not cleared after result");
  chk_se_upper_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $past(q.state == sars_pkg::SARS_DONE) && !$past(diff) && !$past(left_justify_select_i)
    |-> q.result[15:10] == 6'h00) else $error("single-ended upper bits not zero");
  chk_lj_low_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $past(q.state == sars_pkg::SARS_DONE) && $past(left_justify_select_i) |-> q.result[5:0] == 6'h00)
    else $error("left-justified low bits not zero");
  chk_rj_sign_ext: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $past(q.state == sars_pkg::SARS_DONE) && $past(diff) && !$past(left_justify_select_i)
    |-> q.result[15:10] == {6{q.result[9]}}) else $error("sign extension wrong");
  chk_track_len: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(q.state == sars_pkg::SARS_TRACK) |-> (q.state == sars_pkg::SARS_TRACK)[*3])
    else $error("tracking phase too short");

endmodule

`default_nettype wire

// file: bench/sars_far_model.sv
// Far-side model: the analog comparator that answers each trial code.
// Assumes the sequencer raises the trial bit and samples on its tick.
`include "sars_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sars_far_model (
  input  wire logic [`SARS_RES_W-1:0] sar_trial_i,
  input  wire logic [`SARS_RES_W-1:0] target_i,
  output logic                        comparator_high_o
);
  // ****************
  // Comparator
  // ****************
  // Raw code compare, so any sign handling stays in the sequencer
  assign comparator_high_o = (sar_trial_i <= target_i);
endmodule

`default_nettype wire

// file: bench/test_sar_adc_sequencer.sv
// Bench for the converter sequencer: start sources, shutdown, formats, timing.
// Assumes sars_seq and sars_far_model are compiled before it.
`include "sars_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module test_sar_adc_sequencer;
  logic        mclk_i = 1'b0, resetn_i = 1'b0;
  logic        en = 1'b1, lj = 1'b0, lp = 1'b0, ie = 1'b0, clr = 1'b0, spl = 1'b0;
  logic [2:0]  src = 3'h0;
  logic [4:0]  div = 5'h00, pos = 5'h00, neg = 5'h1F, mp, mn;
  logic [7:0]  ev = 8'h00, rh, rl;
  logic [9:0]  tgt = 10'h000, trial;
  logic        cmp, busy, done, irq, trk, dif;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, len, i;
  // Packed as source, split, start expected, event mask
  logic [12:0] src_tab [0:12] = '{13'h0101, 13'h0502, 13'h0404, 13'h0B08, 13'h0A10, 13'h0910, 13'h0808,
                                  13'h0D04, 13'h1180, 13'h1720, 13'h1640, 13'h1540, 13'h1801};
  // Packed as differential, left, comparator target, expected word
  logic [27:0] fmt_tab [0:8] = '{28'h03FF03FF, 28'h07FFFFC0, 28'h02000200, 28'h09FF01FF, 28'h0DFF7FC0,
                                 28'h0A00FE00, 28'h0E008000, 28'h0B00FF00, 28'h05004000};

  sars_seq dut (.mclk_i, .resetn_i, .converter_enable_bit_i(en), .positive_input_select_i(pos),
    .negative_input_select_i(neg), .left_justify_select_i(lj), .conversion_clock_divider_i(div),
    .start_source_select_i(src), .low_power_track_select_i(lp), .busy_write_one_i(ev[0]),
    .timer0_ovf_i(ev[1]), .timer1_ovf_i(ev[2]), .timer2_low_ovf_i(ev[3]), .timer2_high_ovf_i(ev[4]),
    .timer2_split_i(spl), .timer3_low_ovf_i(ev[5]), .timer3_high_ovf_i(ev[6]), .timer3_split_i(spl),
    .external_convert_start_i(ev[7]), .done_clear_i(clr), .interrupt_enable_i(ie),
    .comparator_high_i(cmp), .conversion_in_progress_bit_o(busy), .conversion_done_flag_o(done),
    .interrupt_req_o(irq), .track_o(trk), .differential_o(dif), .mux_pos_o(mp), .mux_neg_o(mn),
    .sar_trial_o(trial), .result_high_byte_o(rh), .result_low_byte_o(rl));

  sars_far_model far (.sar_trial_i(trial), .target_i(tgt), .comparator_high_o(cmp));

  // ****************
  // Clock, timeout, checks
  // ****************
  always #5 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One start event with a done clear; a second start is thrown in mid-conversion
  task automatic conv(input logic [7:0] m, input logic go);
    int k;
    len = 0;
    @(posedge mclk_i);
    ev <= m;
    clr <= 1'b1;
    @(posedge mclk_i);
    ev <= 8'h00;
    clr <= 1'b0;
    #1;
    for (k = 0; k < 3 && busy !== 1'b1; k++) begin
      @(posedge mclk_i);
      #1;
    end
    chk_bit(busy, go);
    chk_bit(done, 1'b0);
    while (busy === 1'b1 && len < 900) begin
      @(posedge mclk_i);
      ev <= (len == 3) ? m : 8'h00;
      #1;
      len++;
      if (len == 5) chk_bit(trk, lp);
    end
    chk_bit(done, go);
    chk_bit(irq, go & ie);
    @(posedge mclk_i);
    ev <= 8'h00;
    #1;
    chk_bit(busy, 1'b0);
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk_bit(busy, 1'b0);
    chk_word({rh, rl}, 16'h0000);
    for (i = 0; i < 13; i++) begin
      @(posedge mclk_i);
      src <= src_tab[i][12:10];
      spl <= src_tab[i][9];
      conv(src_tab[i][7:0], src_tab[i][8]);
    end
    $display("Test start sources done");
    @(posedge mclk_i);
    src <= 3'h0;
    en <= 1'b0;
    conv(8'h01, 1'b0);
    @(posedge mclk_i);
    en <= 1'b1;
    $display("Test shutdown done");
    for (i = 0; i < 9; i++) begin
      @(posedge mclk_i);
      neg <= fmt_tab[i][27] ? 5'h1E : `SARS_MUX_GND;
      lj <= fmt_tab[i][26];
      tgt <= fmt_tab[i][25:16];
      div <= 5'(i * 3);
      lp <= i[0];
      ie <= i[1];
      pos <= 5'(i + 4);
      conv(8'h01, 1'b1);
      chk_word({rh, rl}, fmt_tab[i][15:0]);
      chk_bit(dif, fmt_tab[i][27]);
      chk_word({6'h00, mp, mn}, {6'h00, pos, neg});
      chk_bit(len >= (9 + 3 * lp) * (div + 1) && len <= (10 + 3 * lp) * (div + 1) + 3, 1'b1);
    end
    $display("Test formats and timing done");
    close_out();
  end
endmodule

`default_nettype wire
